//--- hdl/nibble_pkg.sv
// Purpose: constants for the nibble transfer decoder
// Assumes: 10-bit instruction words, one instruction per cycle
// Notes: opcodes are fixed 10-bit words or upper-bit prefixes
// Function
// RQ1: Bank pointer to A1..A0, A3..A2 zero
// RQ2: Stack level to A2..A0, A3 zero
// RQ3: Pair load sets file and digit pointers
// RQ4: Bank load writes two-bit immediate
// RQ5: Digit increment adds one
// RQ6: Digit decrement subtracts one
// RQ7: RAM to accumulator, file pointer XOR j
// RQ8: Exchange accumulator and RAM, XOR j
// RQ9: Exchange, XOR j, digit decrement
// RQ10: Exchange, XOR j, digit increment
// RQ11: Accumulator to RAM, XOR j
// RQ12: Upper register copied to accumulator
// RQ13: Accumulator copied to upper register
// RQ14: Digit pointer copied to accumulator
// RQ15: Accumulator copied to digit pointer
// RQ16: Pack upper and accumulator into wide
// RQ17: Unpack wide into upper and accumulator
// RQ18: Accumulator low three bits to three-bit
// RQ19: Three-bit register to accumulator low bits
// RQ20: File pointer copied to accumulator
// RQ21: Increment result zero skips next
// RQ22: Decrement result fifteen skips next
// RQ23: Back-to-back pair loads: only first executes
// RQ24: One word, one cycle, joint update
// RQ25: Three-bit read clears accumulator bit 3
package nibble_pkg;
  // ==========================================
  // Opcodes (fixed words)
  localparam logic [9:0] OP_READ_BANK = 10'h053;
  localparam logic [9:0] OP_READ_FILE = 10'h052;
  localparam logic [9:0] OP_READ_STACK = 10'h050;
  localparam logic [9:0] OP_INC_DIGIT = 10'h013;
  localparam logic [9:0] OP_DEC_DIGIT = 10'h017;
  localparam logic [9:0] OP_UPPER_TO_ACC = 10'h01E;
  localparam logic [9:0] OP_ACC_TO_UPPER = 10'h00E;
  localparam logic [9:0] OP_DIGIT_TO_ACC = 10'h01F;
  localparam logic [9:0] OP_ACC_TO_DIGIT = 10'h00C;
  localparam logic [9:0] OP_PACK = 10'h01A;
  localparam logic [9:0] OP_UNPACK = 10'h02A;
  localparam logic [9:0] OP_ACC_TO_THREE = 10'h029;
  localparam logic [9:0] OP_THREE_TO_ACC = 10'h051;
  // Opcodes with immediates: upper bits compared
  localparam logic [1:0] OP_PAIR_HI = 2'h3;
  localparam logic [7:0] OP_BANK_HI = 8'h12;
  localparam logic [5:0] OP_RAM_TO_ACC_HI = 6'h2C;
  localparam logic [5:0] OP_XCHG_HI = 6'h2D;
  localparam logic [5:0] OP_XCHG_DEC_HI = 6'h2F;
  localparam logic [5:0] OP_XCHG_INC_HI = 6'h2E;
  localparam logic [5:0] OP_ACC_TO_RAM_HI = 6'h2B;
  // ==========================================
  // Reset values, digit step and skip targets
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [1:0] BANK_RESET = 2'h0;
  localparam logic [7:0] WIDE_RESET = 8'h00;
  localparam logic [2:0] THREE_RESET = 3'h0;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam logic [3:0] INC_SKIP_VALUE = 4'h0;
  localparam logic [3:0] DEC_SKIP_VALUE = 4'hF;
endpackage

//--- hdl/nibble_ram.sv
// Purpose: 4-bit data memory addressed by bank, file and digit pointers
// Assumes: one write per cycle, registered read data
// Notes: read data shows the word addressed on the previous cycle
`timescale 1ns/100ps
module nibble_ram
  import nibble_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [9:0] addr,
  input wire logic wr_en,
  input wire logic [3:0] wr_data,
  output logic [3:0] rd_data
);
  logic [3:0] mem [0:1023];

  // Write port; no reset so it maps onto plain memory
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys) begin
    rd_data <= mem[addr];
  end
endmodule

//--- hdl/nibble_transfer_decoder.sv
// Purpose: execute transfer, RAM-address and RAM transfer instructions
// Assumes: instr_valid marks one word per cycle; RAM is internal
// Notes: RAM read is registered, so a RAM instruction needs the
//   pointer stable for one cycle before it; the address is taken
//   from the current pointers combinationally and the RAM is read
//   through a bypass of the previous cycle's write.
`timescale 1ns/100ps
module nibble_transfer_decoder
  import nibble_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [9:0] instr,
  input wire logic [2:0] stack_level_pointer,
  output logic [3:0] accumulator,
  output logic [3:0] upper_nibble_register,
  output logic [3:0] ram_file_pointer,
  output logic [3:0] ram_digit_pointer,
  output logic [1:0] ram_bank_pointer,
  output logic [7:0] eight_bit_register,
  output logic [2:0] three_bit_register,
  output logic skip_next,
  output logic [3:0] addressed_ram_nibble
);
  // ==========================================
  // Registers
  logic [3:0] acc_reg, acc_next;
  logic [3:0] upper_reg, upper_next;
  logic [3:0] file_reg, file_next;
  logic [3:0] digit_reg, digit_next;
  logic [1:0] bank_reg, bank_next;
  logic [7:0] wide_reg, wide_next;
  logic [2:0] three_reg, three_next;
  logic skip_reg, skip_next_v;
  logic pair_reg, pair_next;
  logic ram_we;
  logic [3:0] ram_wdata;
  logic [3:0] ram_q;
  logic [9:0] ram_addr;
  logic [9:0] last_addr_reg;
  logic [3:0] last_wdata_reg;
  logic last_we_reg;
  logic [3:0] ram_now;
  logic exec;
  logic chain_skip;
  logic [3:0] imm;

  // Decoding used by several instructions
  function automatic logic is_ram_xfer(input logic [9:0] w);
    is_ram_xfer = (w[9:4] == OP_RAM_TO_ACC_HI) ||
      (w[9:4] == OP_XCHG_HI) || (w[9:4] == OP_XCHG_DEC_HI) ||
      (w[9:4] == OP_XCHG_INC_HI) || (w[9:4] == OP_ACC_TO_RAM_HI);
  endfunction

  function automatic logic is_exchange(input logic [9:0] w);
    is_exchange = (w[9:4] == OP_XCHG_HI) ||
      (w[9:4] == OP_XCHG_DEC_HI) || (w[9:4] == OP_XCHG_INC_HI);
  endfunction

  assign imm = instr[3:0];
  // A pair load right after a pair load is passed over, so a chain
  // sets the pointers once and the next other word still runs
  assign chain_skip = instr_valid && pair_reg && instr[9:8] == OP_PAIR_HI;
  // A skipped word still occupies its cycle but changes nothing
  assign exec = instr_valid && !skip_reg && !chain_skip;
  assign ram_addr = {bank_reg, file_reg, digit_reg};

  // ==========================================
  // Data memory
  nibble_ram i_nibble_ram (
    .clk_sys(clk_sys),
    .addr(ram_addr),
    .wr_en(ram_we),
    .wr_data(ram_wdata),
    .rd_data(ram_q)
  );

  // Track last access; registered read returns old data after a write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_addr_reg <= 10'h000;
      last_wdata_reg <= NIBBLE_RESET;
      last_we_reg <= 1'b0;
    end else begin
      last_addr_reg <= ram_addr;
      last_wdata_reg <= ram_wdata;
      last_we_reg <= ram_we;
    end
  end

  // Current RAM word: valid when the address was held one cycle
  always_comb begin
    if (last_we_reg && last_addr_reg == ram_addr) begin
      ram_now = last_wdata_reg;
    end else begin
      ram_now = ram_q;
    end
  end

  // ==========================================
  // Next-state decode; all destinations change together
  always_comb begin
    acc_next = acc_reg;
    upper_next = upper_reg;
    file_next = file_reg;
    digit_next = digit_reg;
    bank_next = bank_reg;
    wide_next = wide_reg;
    three_next = three_reg;
    skip_next_v = 1'b0;
    pair_next = 1'b0;
    ram_we = 1'b0;
    ram_wdata = acc_reg;
    if (chain_skip) begin
      pair_next = 1'b1; // RQ23
    end
    if (exec) begin // RQ24
      if (instr[9:8] == OP_PAIR_HI) begin
        file_next = instr[7:4]; // RQ3
        digit_next = imm; // RQ3
        pair_next = 1'b1; // RQ23
      end else if (instr[9:2] == OP_BANK_HI) begin
        bank_next = instr[1:0]; // RQ4
      end else if (is_ram_xfer(instr)) begin
        file_next = file_reg ^ imm; // RQ7 RQ8 RQ11
        if (instr[9:4] == OP_ACC_TO_RAM_HI) begin
          ram_we = 1'b1; // RQ11
        end else begin
          acc_next = ram_now; // RQ7
        end
        if (is_exchange(instr)) begin
          ram_we = 1'b1; // RQ8
        end
        if (instr[9:4] == OP_XCHG_DEC_HI) begin
          digit_next = digit_reg - DIGIT_ONE; // RQ9
          skip_next_v = (digit_next == DEC_SKIP_VALUE); // RQ22
        end
        if (instr[9:4] == OP_XCHG_INC_HI) begin
          digit_next = digit_reg + DIGIT_ONE; // RQ10
          skip_next_v = (digit_next == INC_SKIP_VALUE); // RQ21
        end
      end else begin
        unique case (instr)
          OP_READ_BANK: acc_next = {2'h0, bank_reg}; // RQ1
          OP_READ_FILE: acc_next = file_reg; // RQ20
          OP_READ_STACK: acc_next = {1'b0, stack_level_pointer}; // RQ2
          OP_INC_DIGIT: begin
            digit_next = digit_reg + DIGIT_ONE; // RQ5
            skip_next_v = (digit_next == INC_SKIP_VALUE); // RQ21
          end
          OP_DEC_DIGIT: begin
            digit_next = digit_reg - DIGIT_ONE; // RQ6
            skip_next_v = (digit_next == DEC_SKIP_VALUE); // RQ22
          end
          OP_UPPER_TO_ACC: acc_next = upper_reg; // RQ12
          OP_ACC_TO_UPPER: upper_next = acc_reg; // RQ13
          OP_DIGIT_TO_ACC: acc_next = digit_reg; // RQ14
          OP_ACC_TO_DIGIT: digit_next = acc_reg; // RQ15
          OP_PACK: wide_next = {upper_reg, acc_reg}; // RQ16
          OP_UNPACK: begin
            upper_next = wide_reg[7:4]; // RQ17
            acc_next = wide_reg[3:0]; // RQ17
          end
          OP_ACC_TO_THREE: three_next = acc_reg[2:0]; // RQ18
          OP_THREE_TO_ACC: acc_next = {1'b0, three_reg}; // RQ19 RQ25
          default: acc_next = acc_reg; // Other groups handled elsewhere
        endcase
      end
    end
  end

  // Working registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_reg <= NIBBLE_RESET;
      upper_reg <= NIBBLE_RESET;
      wide_reg <= WIDE_RESET;
      three_reg <= THREE_RESET;
    end else begin
      acc_reg <= acc_next;
      upper_reg <= upper_next;
      wide_reg <= wide_next;
      three_reg <= three_next;
    end
  end

  // RAM pointers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      file_reg <= NIBBLE_RESET;
      digit_reg <= NIBBLE_RESET;
      bank_reg <= BANK_RESET;
    end else begin
      file_reg <= file_next;
      digit_reg <= digit_next;
      bank_reg <= bank_next;
    end
  end

  // Skip state; held across idle cycles until the next word arrives
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      skip_reg <= 1'b0;
      pair_reg <= 1'b0;
    end else if (instr_valid) begin
      skip_reg <= skip_next_v;
      pair_reg <= pair_next;
    end
  end

  assign accumulator = acc_reg;
  assign upper_nibble_register = upper_reg;
  assign ram_file_pointer = file_reg;
  assign ram_digit_pointer = digit_reg;
  assign ram_bank_pointer = bank_reg;
  assign eight_bit_register = wide_reg;
  assign three_bit_register = three_reg;
  assign skip_next = skip_reg;
  assign addressed_ram_nibble = ram_now;

  // ==========================================
  // Checks
  property p_bank_read;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_READ_BANK |=> accumulator == {2'h0, $past(bank_reg)};
  endproperty
  a_bank_read: assert property (p_bank_read) // RQ1
    else $error("bank read wrong");

  property p_stack_read;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_READ_STACK |=>
        accumulator == {1'b0, $past(stack_level_pointer)};
  endproperty
  a_stack_read: assert property (p_stack_read) // RQ2
    else $error("stack level read wrong");

  property p_pair_load;
    @(posedge clk_sys) disable iff (reset)
      exec && instr[9:8] == OP_PAIR_HI |=>
        {ram_file_pointer, ram_digit_pointer} == $past(instr[7:0]);
  endproperty
  a_pair_load: assert property (p_pair_load) // RQ3
    else $error("pair load wrong");

  property p_inc;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_INC_DIGIT |=>
        ram_digit_pointer == $past(digit_reg) + 4'h1 &&
        skip_next == (ram_digit_pointer == 4'h0);
  endproperty
  a_inc: assert property (p_inc) // RQ21
    else $error("increment or skip wrong");

  property p_dec;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_DEC_DIGIT |=>
        ram_digit_pointer == $past(digit_reg) - 4'h1 &&
        skip_next == (ram_digit_pointer == 4'hF);
  endproperty
  a_dec: assert property (p_dec) // RQ22
    else $error("decrement or skip wrong");

  property p_xor;
    @(posedge clk_sys) disable iff (reset)
      exec && is_ram_xfer(instr) |=>
        ram_file_pointer == ($past(file_reg) ^ $past(instr[3:0]));
  endproperty
  a_xor: assert property (p_xor) // RQ7
    else $error("file pointer xor wrong");

  property p_pair_chain;
    @(posedge clk_sys) disable iff (reset)
      exec && instr[9:8] == OP_PAIR_HI ##1
        instr_valid && instr[9:8] == OP_PAIR_HI |=>
        $stable(ram_file_pointer) && $stable(ram_digit_pointer);
  endproperty
  a_pair_chain: assert property (p_pair_chain) // RQ23
    else $error("second pair load executed");

  property p_three_read;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_THREE_TO_ACC |=>
        accumulator == {1'b0, $past(three_reg)};
  endproperty
  a_three_read: assert property (p_three_read) // RQ25
    else $error("three-bit read wrong");

  property p_pack;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_PACK |=>
        eight_bit_register == {$past(upper_reg), $past(acc_reg)};
  endproperty
  a_pack: assert property (p_pack) // RQ16
    else $error("pack wrong");

  property p_file_read;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_READ_FILE |=> accumulator == $past(file_reg);
  endproperty
  a_file_read: assert property (p_file_read) // RQ20
    else $error("file pointer read wrong");

  property p_bank_load;
    @(posedge clk_sys) disable iff (reset)
      exec && instr[9:2] == OP_BANK_HI |=>
        ram_bank_pointer == $past(instr[1:0]);
  endproperty
  a_bank_load: assert property (p_bank_load) // RQ4
    else $error("bank load wrong");

  property p_upper_copy;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_ACC_TO_UPPER |=>
        upper_nibble_register == $past(acc_reg);
  endproperty
  a_upper_copy: assert property (p_upper_copy) // RQ13
    else $error("upper copy wrong");

  property p_unpack;
    @(posedge clk_sys) disable iff (reset)
      exec && instr == OP_UNPACK |=>
        {upper_nibble_register, accumulator} == $past(wide_reg);
  endproperty
  a_unpack: assert property (p_unpack) // RQ17
    else $error("unpack wrong");

  // With j zero the address stays, so the stored word is visible next
  property p_xchg_store;
    @(posedge clk_sys) disable iff (reset)
      exec && instr[9:4] == OP_XCHG_HI && imm == 4'h0 |=>
        addressed_ram_nibble == $past(accumulator);
  endproperty
  a_xchg_store: assert property (p_xchg_store) // RQ8
    else $error("exchange store wrong");

  property p_acc_store;
    @(posedge clk_sys) disable iff (reset)
      exec && instr[9:4] == OP_ACC_TO_RAM_HI && imm == 4'h0 |=>
        addressed_ram_nibble == $past(accumulator);
  endproperty
  a_acc_store: assert property (p_acc_store) // RQ11
    else $error("accumulator store wrong");

  // A skipped word must leave the working state alone
  property p_skipped;
    @(posedge clk_sys) disable iff (reset)
      instr_valid && !exec |=> $stable(accumulator) &&
        $stable(ram_file_pointer) && $stable(ram_digit_pointer);
  endproperty
  a_skipped: assert property (p_skipped) // RQ24
    else $error("skipped word changed state");
endmodule

//--- tb/nibble_transfer_decoder_bench.sv
// Purpose: self-checking bench for the nibble transfer decoder
// Assumes: one instruction per cycle, results visible after the edge
// Notes: state is compared as one nibble-aligned vector, digits
//   acc, upper, file, digit, bank, wide (two), three-bit, skip
`timescale 1ns/100ps
module nibble_transfer_decoder_bench;
  import nibble_pkg::*;

  // ==========================================
  // Signals and bookkeeping
  localparam logic [35:0] CARE_ALL = 36'hFFFFFFFFF;
  localparam logic [35:0] CARE_NOSKIP = 36'hFFFFFFFF0;
  typedef struct {
    logic [9:0] op;
    logic [2:0] sp;
    logic [35:0] exp;
    logic care_skip;
  } row_type;
  row_type rows[$];
  logic clk_sys;
  logic reset;
  logic instr_valid;
  logic [9:0] instr;
  logic [2:0] stack_level_pointer;
  logic [3:0] accumulator;
  logic [3:0] upper_nibble_register;
  logic [3:0] ram_file_pointer;
  logic [3:0] ram_digit_pointer;
  logic [1:0] ram_bank_pointer;
  logic [7:0] eight_bit_register;
  logic [2:0] three_bit_register;
  logic skip_next;
  logic [3:0] addressed_ram_nibble;
  logic [35:0] seen;
  int fail_count = 0;
  int samples_checked = 0;

  // Nibble-aligned view so expectations read as hex digits
  assign seen = {accumulator, upper_nibble_register, ram_file_pointer,
    ram_digit_pointer, 2'h0, ram_bank_pointer, eight_bit_register, 1'h0,
    three_bit_register, 3'h0, skip_next};

  nibble_transfer_decoder i_nibble_transfer_decoder (
    .clk_sys(clk_sys),
    .reset(reset),
    .instr_valid(instr_valid),
    .instr(instr),
    .stack_level_pointer(stack_level_pointer),
    .accumulator(accumulator),
    .upper_nibble_register(upper_nibble_register),
    .ram_file_pointer(ram_file_pointer),
    .ram_digit_pointer(ram_digit_pointer),
    .ram_bank_pointer(ram_bank_pointer),
    .eight_bit_register(eight_bit_register),
    .three_bit_register(three_bit_register),
    .skip_next(skip_next),
    .addressed_ram_nibble(addressed_ram_nibble)
  );

  // ==========================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // About 60 cycles are needed; a hang is cut well beyond that
  initial begin
    #16000;
    fail_count++;
    final_report();
  end

  // ==========================================
  // Tasks
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  // Drive one word just after an edge, compare just after the next one
  task automatic step(input logic [9:0] op, input logic [2:0] sp,
      input logic v, input logic [35:0] exp, input logic [35:0] care);
    instr <= op;
    stack_level_pointer <= sp;
    instr_valid <= v;
    @(posedge clk_sys);
    #1;
    check(seen & care, exp & care);
  endtask

  function automatic void add(logic [9:0] op, logic [2:0] sp,
      logic [35:0] exp, logic c);
    rows.push_back('{op, sp, exp, c});
  endfunction

  task automatic final_report();
    $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    reset = 1'b1;
    instr_valid = 1'b0;
    instr = 10'h000;
    stack_level_pointer = 3'h0;
    // Pointer changes are kept one word away from RAM reads
    add(10'h3A5, 3'h7, 36'h00A5_0_00_0_0, 1'b0);
    add(10'h3C7, 3'h7, 36'h00A5_0_00_0_0, 1'b0);
    add(10'h01F, 3'h7, 36'h50A5_0_00_0_0, 1'b1);
    add(10'h00E, 3'h7, 36'h55A5_0_00_0_0, 1'b1);
    add(10'h3EF, 3'h7, 36'h55EF_0_00_0_0, 1'b0);
    add(10'h01F, 3'h7, 36'hF5EF_0_00_0_0, 1'b1);
    add(10'h050, 3'h2, 36'h25EF_0_00_0_0, 1'b1);
    add(10'h01F, 3'h7, 36'hF5EF_0_00_0_0, 1'b1);
    add(10'h049, 3'h7, 36'hF5EF_1_00_0_0, 1'b1);
    add(10'h053, 3'h7, 36'h15EF_1_00_0_0, 1'b1);
    add(10'h052, 3'h7, 36'hE5EF_1_00_0_0, 1'b1);
    add(10'h00C, 3'h7, 36'hE5EE_1_00_0_0, 1'b1);
    add(10'h01A, 3'h7, 36'hE5EE_1_5E_0_0, 1'b1);
    add(10'h01E, 3'h7, 36'h55EE_1_5E_0_0, 1'b1);
    add(10'h029, 3'h7, 36'h55EE_1_5E_5_0, 1'b1);
    add(10'h01F, 3'h7, 36'hE5EE_1_5E_5_0, 1'b1);
    add(10'h00E, 3'h7, 36'hEEEE_1_5E_5_0, 1'b1);
    add(10'h051, 3'h7, 36'h5EEE_1_5E_5_0, 1'b1);
    add(10'h02A, 3'h7, 36'hE5EE_1_5E_5_0, 1'b1);
    add(10'h013, 3'h7, 36'hE5EF_1_5E_5_0, 1'b1);
    add(10'h013, 3'h7, 36'hE5E0_1_5E_5_1, 1'b1);
    add(10'h00E, 3'h7, 36'hE5E0_1_5E_5_0, 1'b1);
    add(10'h017, 3'h7, 36'hE5EF_1_5E_5_1, 1'b1);
    add(10'h01F, 3'h7, 36'hE5EF_1_5E_5_0, 1'b1);
    add(10'h017, 3'h7, 36'hE5EE_1_5E_5_0, 1'b1);
    add(10'h00E, 3'h7, 36'hEEEE_1_5E_5_0, 1'b1);
    add(10'h2B0, 3'h7, 36'hEEEE_1_5E_5_0, 1'b1);
    add(10'h051, 3'h7, 36'h5EEE_1_5E_5_0, 1'b1);
    add(10'h2C3, 3'h7, 36'hEEDE_1_5E_5_0, 1'b1);
    add(10'h00E, 3'h7, 36'hEEDE_1_5E_5_0, 1'b1);
    add(10'h051, 3'h7, 36'h5EDE_1_5E_5_0, 1'b1);
    add(10'h2B0, 3'h7, 36'h5EDE_1_5E_5_0, 1'b1);
    add(10'h01F, 3'h7, 36'hEEDE_1_5E_5_0, 1'b1);
    add(10'h2D0, 3'h7, 36'h5EDE_1_5E_5_0, 1'b1);
    add(10'h2F6, 3'h7, 36'hEEBD_1_5E_5_0, 1'b1);
    add(10'h01F, 3'h7, 36'hDEBD_1_5E_5_0, 1'b1);
    add(10'h2B0, 3'h7, 36'hDEBD_1_5E_5_0, 1'b1);
    add(10'h051, 3'h7, 36'h5EBD_1_5E_5_0, 1'b1);
    add(10'h2EF, 3'h7, 36'hDE4E_1_5E_5_0, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    reset <= 1'b0;
    check(seen, 36'h0);
    // Ordinary cases, back to back
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].sp, 1'b1, rows[i].exp,
        rows[i].care_skip ? CARE_ALL : CARE_NOSKIP);
    end
    // Stored word seen at once, then through the registered port
    step(10'h2B0, 3'h7, 1'b1, 36'hDE4E_1_5E_5_0, CARE_ALL);
    check({32'h0, addressed_ram_nibble}, 36'hD);
    step(10'h01E, 3'h7, 1'b0, 36'hDE4E_1_5E_5_0, CARE_ALL);
    check({32'h0, addressed_ram_nibble}, 36'hD);
    // Every bank code, read back through the accumulator
    for (int z = 0; z < 4; z++) begin
      step(10'h048 | 10'(z), 3'h7, 1'b1, {16'h0, 2'h0, 2'(z), 16'h0},
        36'h0000_F_00_0_0);
      step(10'h053, 3'h7, 1'b1, {2'h0, 2'(z), 32'h0},
        36'hF000_0_00_0_0);
    end
    // Chain of three pair loads with boundary values
    step(10'h3F0, 3'h7, 1'b1, 36'h3EF0_3_5E_5_0, CARE_NOSKIP);
    step(10'h312, 3'h7, 1'b1, 36'h3EF0_3_5E_5_0, CARE_NOSKIP);
    step(10'h321, 3'h7, 1'b1, 36'h3EF0_3_5E_5_0, CARE_NOSKIP);
    step(10'h01F, 3'h7, 1'b1, 36'h0EF0_3_5E_5_0, CARE_ALL);
    // A word without valid must change nothing
    step(10'h01E, 3'h7, 1'b0, 36'h0EF0_3_5E_5_0, CARE_ALL);
    // Reset in mid-run wins over a valid word
    reset <= 1'b1;
    step(10'h01E, 3'h7, 1'b1, 36'h0, CARE_ALL);
    reset <= 1'b0;
    step(10'h00C, 3'h7, 1'b1, 36'h0, CARE_ALL);
    final_report();
  end
endmodule
